// >>> shared/scc_pkg.sv
// six-channel sar conversion control: shared constants and types
// assumes a single 100 MHz system clock; all timing counts derive from it

package scc_pkg;

    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int PAIRS = 3;
    localparam int DAC_BITS = 10;
    localparam int EVT_BITS = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 100;
    // 18.5 conversion-clock cycles counted as both edges
    localparam int CONV_HALF_CYCLES = 37;
    localparam logic [5:0] CONV_LAST_EDGE = 6'(CONV_HALF_CYCLES - 1);
    // pre-charge occupies the final half cycle of the conversion
    localparam logic [5:0] PRECHG_FIRST_EDGE = 6'(CONV_HALF_CYCLES - 1);
    // internal conversion clock half period (about 16.7 MHz)
    localparam int INT_HALF_PERIOD_NS = 30;
    localparam int INT_HALF_CYC_I = (INT_HALF_PERIOD_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] INT_HALF_CYC = 4'(INT_HALF_CYC_I < 1 ? 1 : INT_HALF_CYC_I);
    // external conversion clock limits and shortest conversion
    localparam int EXT_CLK_MAX_MHZ = 20;
    localparam int CONV_MIN_NS = 925;
    // reference dac step in microvolts for the two reference levels
    localparam int REF_STEP_2V5_UV = 2441;
    localparam int REF_STEP_3V_UV = 2930;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_STEP = 4'h8;

    // control word fields
    localparam int CTL_DAC_LSB = 0;
    localparam int CTL_CLKSRC = 10;
    localparam int CTL_REFLVL = 11;
    localparam int CTL_BUSYPOL = 12;
    localparam int CTL_SWMODE = 13;
    localparam int CTL_SEQ = 14;
    localparam int CTL_RANGE_LSB = 15;
    localparam int CTL_USED = 18;
    localparam logic [31:0] CTL_RESET = 32'h0000_03ff;

    // status word fields
    localparam int STS_BUSY = 0;
    localparam int STS_TRIG_LSB = 1;
    localparam int STS_PDOWN_LSB = 4;
    localparam int STS_RANGE = 7;
    localparam int STS_EVT_LSB = 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_CONV,
        ST_GAP
    } scc_state_t;

endpackage

// >>> verilog/scc_start_edges.sv
// per-pair edge detection on the conversion start inputs
// assumes the start inputs are already synchronous to sys_clk
`timescale 1ns/1ps

module scc_start_edges
    import scc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // start levels and their edges
    input wire logic [PAIRS-1:0] pair_conversion_start,
    output logic [PAIRS-1:0] start_rise,
    output logic [PAIRS-1:0] start_fall
);

    // ------------------------------------------------------------
    // one detector per pair
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : g_pair
            logic prev_q;
            logic prev_d;
            always_comb begin
                prev_d = pair_conversion_start[g];
            end
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= prev_d;
                end
            end
            assign start_rise[g] = pair_conversion_start[g] & ~prev_q;
            assign start_fall[g] = ~pair_conversion_start[g] & prev_q;
        end
    endgenerate

endmodule

// >>> verilog/scc_conv_clock.sv
// conversion clock edge source: internal divider or external clock edges
// assumes the external clock is synchronous to sys_clk and at most 20 MHz
`timescale 1ns/1ps

module scc_conv_clock
    import scc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic use_external,
    input wire logic run,
    input wire logic external_conversion_clock,
    // one-cycle pulse per conversion clock edge (rising or falling)
    output logic conv_edge
);

    logic [3:0] div_q;
    logic [3:0] div_d;
    logic ext_q;
    logic ext_d;
    logic int_edge;

    // ------------------------------------------------------------
    // internal divider, restarted when idle so edges align to a start
    // ------------------------------------------------------------
    assign int_edge = run && (div_q == INT_HALF_CYC - 4'h1);

    always_comb begin
        div_d = div_q;
        if (!run || int_edge) begin
            div_d = 4'h0;
        end else begin
            div_d = div_q + 4'h1;
        end
        ext_d = external_conversion_clock;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_q <= 4'h0;
            ext_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ext_q <= ext_d;
        end
    end

    // external clock may stand low between conversions; only edges count
    assign conv_edge = use_external ? (run && (external_conversion_clock ^ ext_q)) : int_edge;
endmodule

// >>> verilog/scc_top.sv
// conversion control for six sar converters grouped in three pairs
// assumes start inputs and external clock are synchronous to sys_clk,
// and a classic wishbone master for the control and status words
//
// Contract
// - six converters form three pairs; both channels of a pair convert together
// - pair span wide or narrow: range pin in hardware mode, range bits in software
// - reference level bit selects 2.5 V when clear, 3 V when set
// - with busy polarity bit clear, range pin is latched at busy falling edge
// - reference feeds a 10-bit dac with 2.44 mV or 2.93 mV steps
// - conversion clock is internal by default
// - software mode with clock source bit set uses the external clock
// - a conversion lasts 18.5 conversion-clock cycles on either clock
// - start rising edge holds that pair's inputs for conversion
// - software mode outside sequential mode: master start triggers all pairs
// - conversion begins on next conversion clock edge after sampling
// - start must stay high; falling during conversion powers that pair down
// - outside sequential mode, starts during a conversion are ignored
// - sampling capacitors are pre-charged before sampling resumes
// - external clock at 20 MHz gives the 925 ns shortest conversion
// - busy rises on a pair start edge (master start only, in software mode outside sequential mode), falls when last pair results are ready
// - busy output polarity follows the busy polarity bit
// - in sequential mode busy drops low for one cycle between conversions
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module scc_top
    import scc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // conversion starts and clock
    input wire logic [PAIRS-1:0] pair_conversion_start,
    input wire logic external_conversion_clock,
    input wire logic range_pin,
    // converter control outputs
    output logic busy_int,
    output logic [PAIRS-1:0] pair_sample_hold,
    output logic [PAIRS-1:0] pair_result_ready,
    output logic [PAIRS-1:0] pair_power_down,
    output logic [PAIRS-1:0] pair_range_wide,
    output logic precharge_active,
    output logic reference_3v,
    output logic [DAC_BITS-1:0] reference_dac_code
);

    // ------------------------------------------------------------
    // register bus state
    // ------------------------------------------------------------
    logic [CTL_USED-1:0] control_word_q;
    logic [CTL_USED-1:0] control_word_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] wmask;
    logic [31:0] ctl_ext;

    // ------------------------------------------------------------
    // conversion state
    // ------------------------------------------------------------
    scc_state_t state_q;
    scc_state_t state_d;
    logic [5:0] edge_cnt_q;
    logic [5:0] edge_cnt_d;
    logic [PAIRS-1:0] trig_q;
    logic [PAIRS-1:0] trig_d;
    logic [PAIRS-1:0] pend_q;
    logic [PAIRS-1:0] pend_d;
    logic [PAIRS-1:0] hold_q;
    logic [PAIRS-1:0] hold_d;
    logic [PAIRS-1:0] pdown_q;
    logic [PAIRS-1:0] pdown_d;
    logic [PAIRS-1:0] ready_q;
    logic [PAIRS-1:0] ready_d;
    logic busy_q;
    logic busy_d;
    logic busy_int_q;
    logic busy_int_d;
    logic prechg_q;
    logic prechg_d;
    logic range_latch_q;
    logic range_latch_d;
    logic [EVT_BITS-1:0] evt_q;
    logic [EVT_BITS-1:0] evt_d;

    logic [PAIRS-1:0] start_rise;
    logic [PAIRS-1:0] start_fall;
    logic [PAIRS-1:0] eff_rise;
    logic [PAIRS-1:0] eff_fall;
    logic conv_edge;
    logic clk_run;
    logic sw_mode;
    logic seq_mode;
    logic busy_pol;
    logic last_edge;

    assign sw_mode = control_word_q[CTL_SWMODE];
    assign seq_mode = control_word_q[CTL_SEQ];
    assign busy_pol = control_word_q[CTL_BUSYPOL];

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    scc_start_edges u_edges (
        .sys_clk(sys_clk),
        .rst(rst),
        .pair_conversion_start(pair_conversion_start),
        .start_rise(start_rise),
        .start_fall(start_fall)
    );

    // clock only runs while waiting or converting, so a stopped clock is harmless
    assign clk_run = (state_q == ST_WAIT) || (state_q == ST_CONV);

    scc_conv_clock u_clk (
        .sys_clk(sys_clk),
        .rst(rst),
        .use_external(sw_mode && control_word_q[CTL_CLKSRC]),
        .run(clk_run),
        .external_conversion_clock(external_conversion_clock),
        .conv_edge(conv_edge)
    );

    // ------------------------------------------------------------
    // start steering
    // ------------------------------------------------------------
    always_comb begin
        if (sw_mode && !seq_mode) begin
            eff_rise = {PAIRS{start_rise[0]}};
            eff_fall = {PAIRS{start_fall[0]}};
        end else begin
            eff_rise = start_rise;
            eff_fall = start_fall;
        end
    end

    assign last_edge = conv_edge && (edge_cnt_q == CONV_LAST_EDGE);

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        edge_cnt_d = edge_cnt_q;
        trig_d = trig_q;
        pend_d = pend_q;
        hold_d = hold_q;
        ready_d = '0;
        pdown_d = pdown_q & ~eff_rise;
        evt_d = evt_q;
        case (state_q)
            ST_IDLE: begin
                if (|eff_rise) begin
                    trig_d = eff_rise;
                    hold_d = eff_rise;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (conv_edge) begin
                    edge_cnt_d = 6'h0;
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (seq_mode) begin
                    pend_d = pend_q | eff_rise;
                end
                // early release powers the pair down and drops it from the result
                if (|(eff_fall & trig_q)) begin
                    pdown_d = pdown_q | (eff_fall & trig_q);
                    trig_d = trig_q & ~eff_fall;
                    hold_d = hold_q & ~eff_fall;
                end
                if (conv_edge) begin
                    edge_cnt_d = edge_cnt_q + 6'h1;
                end
                if (last_edge) begin
                    ready_d = trig_q & ~eff_fall;
                    hold_d = '0;
                    evt_d = evt_q + 8'h01;
                    if (seq_mode && |pend_d) begin
                        state_d = ST_GAP;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_GAP: begin
                trig_d = pend_q;
                hold_d = pend_q;
                pend_d = eff_rise;
                state_d = ST_WAIT;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // busy raised the cycle after a start edge, dropped with results
        busy_d = (state_d == ST_WAIT) || (state_d == ST_CONV);
        busy_int_d = busy_d ^ busy_pol;
        prechg_d = (state_d == ST_CONV) && (edge_cnt_d >= PRECHG_FIRST_EDGE);
        range_latch_d = range_latch_q;
        if (busy_q && !busy_d && !busy_pol) begin
            range_latch_d = range_pin;
        end else if (busy_pol && (state_q == ST_IDLE) && |eff_rise) begin
            range_latch_d = range_pin;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            edge_cnt_q <= 6'h0;
            trig_q <= '0;
            pend_q <= '0;
            hold_q <= '0;
            pdown_q <= '0;
            ready_q <= '0;
            busy_q <= 1'b0;
            busy_int_q <= 1'b0;
            prechg_q <= 1'b0;
            range_latch_q <= 1'b0;
            evt_q <= '0;
        end else begin
            state_q <= state_d;
            edge_cnt_q <= edge_cnt_d;
            trig_q <= trig_d;
            pend_q <= pend_d;
            hold_q <= hold_d;
            pdown_q <= pdown_d;
            ready_q <= ready_d;
            busy_q <= busy_d;
            busy_int_q <= busy_int_d;
            prechg_q <= prechg_d;
            range_latch_q <= range_latch_d;
            evt_q <= evt_d;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: one wait state, ack for exactly one cycle
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
    end

    assign ctl_ext = {{(32-CTL_USED){1'b0}}, control_word_q};

    always_comb begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        control_word_d = control_word_q;
        rdata_d = rdata_q;
        if (ack_d) begin
            rdata_d = 32'h0;
            case (wb_adr_i)
                ADDR_CTRL: begin
                    rdata_d = ctl_ext;
                    if (wb_we_i) begin
                        control_word_d = CTL_USED'((ctl_ext & ~wmask) | (wb_dat_i & wmask));
                    end
                end
                ADDR_STATUS: begin
                    rdata_d[STS_BUSY] = busy_q;
                    rdata_d[STS_TRIG_LSB +: PAIRS] = trig_q;
                    rdata_d[STS_PDOWN_LSB +: PAIRS] = pdown_q;
                    rdata_d[STS_RANGE] = range_latch_q;
                    rdata_d[STS_EVT_LSB +: EVT_BITS] = evt_q;
                end
                ADDR_STEP: begin
                    // step size of the reference dac for the active level
                    rdata_d = control_word_q[CTL_REFLVL] ? 32'(REF_STEP_3V_UV)
                                                         : 32'(REF_STEP_2V5_UV);
                end
                default: begin
                    rdata_d = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            control_word_q <= CTL_USED'(CTL_RESET);
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            control_word_q <= control_word_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign busy_int = busy_int_q;
    assign pair_sample_hold = hold_q;
    assign pair_result_ready = ready_q;
    assign pair_power_down = pdown_q;
    assign precharge_active = prechg_q;
    assign reference_3v = control_word_q[CTL_REFLVL];
    assign reference_dac_code = control_word_q[CTL_DAC_LSB +: DAC_BITS];
    // hardware mode uses the latched pin for all pairs
    assign pair_range_wide = sw_mode ? control_word_q[CTL_RANGE_LSB +: PAIRS]
                                     : {PAIRS{range_latch_q}};

endmodule

// >>> test/scc_top_sva.sv
// assertions for the conversion control top level
// assumes binding to scc_top; control bits are shadowed from bus writes
`timescale 1ns/1ps

module scc_top_sva
    import scc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // conversion
    input wire logic [PAIRS-1:0] pair_conversion_start,
    input wire logic busy_int,
    input wire logic [PAIRS-1:0] pair_sample_hold,
    input wire logic [PAIRS-1:0] pair_result_ready,
    input wire logic [PAIRS-1:0] pair_power_down,
    input wire logic precharge_active,
    input wire logic reference_3v,
    input wire logic [DAC_BITS-1:0] reference_dac_code
);
    // --------------------
    // helper state
    // --------------------
    logic [PAIRS-1:0] start_q, start_d, rise, fall_hold;
    // shadow of clock source, reference, polarity, software mode
    logic [3:0] ctl_q, ctl_d;
    logic [8:0] cnt_q, cnt_d;
    logic idle, take_ctl;
    assign rise = pair_conversion_start & ~start_q;
    assign fall_hold = pair_sample_hold & start_q & ~pair_conversion_start;
    assign idle = busy_int == ctl_q[2];
    assign take_ctl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == ADDR_CTRL && wb_sel_i[1];
    always_comb begin
        start_d = rst ? '0 : pair_conversion_start;
        ctl_d = rst ? 4'h0 : (take_ctl ? wb_dat_i[13:10] : ctl_q);
        // saturates so a long idle spell never wraps into a false length
        cnt_d = (idle && |rise) ? 9'h0 : (cnt_q == 9'h1ff ? cnt_q : cnt_q + 9'h1);
    end
    always_ff @(posedge sys_clk) begin
        start_q <= start_d;
        ctl_q <= ctl_d;
        cnt_q <= cnt_d;
    end
    // --------------------
    // properties
    // --------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_start;
        idle && rise[0];
    endsequence
    AST_ACK_ONE: assert property (s_take |=> s_ack_pulse)
        else $error("ack not one pulse");
    AST_START_BUSY: assert property (s_start |=> !idle && pair_sample_hold[0])
        else $error("start not taken");
    AST_SW_ALL: assert property (ctl_q[3] ##0 s_start |=> pair_sample_hold == 3'b111)
        else $error("not all pairs held");
    AST_HW_MASK: assert property (!ctl_q[3] && idle && |rise |=> pair_sample_hold == $past(rise))
        else $error("held pairs wrong");
    AST_BLOCK: assert property (|pair_sample_hold && |rise
        |=> (pair_sample_hold & ~$past(pair_sample_hold)) == 3'b000)
        else $error("start not blocked");
    AST_PDOWN: assert property (!ctl_q[3] && |fall_hold
        |=> (pair_power_down & $past(fall_hold)) == $past(fall_hold))
        else $error("no power-down");
    AST_READY: assert property (|pair_result_ready
        |-> pair_result_ready == $past(pair_sample_hold) && pair_sample_hold == 3'b000 && idle)
        else $error("ready mismatch");
    AST_READY_PULSE: assert property (|pair_result_ready |=> pair_result_ready == 3'b000)
        else $error("ready too long");
    AST_INT_LEN: assert property (!(ctl_q[0] && ctl_q[3]) && |pair_result_ready
        |-> cnt_q inside {[108:120]})
        else $error("internal length");
    AST_EXT_LEN: assert property (ctl_q[0] && ctl_q[3] && |pair_result_ready
        |-> cnt_q inside {[140:160]})
        else $error("external length");
    AST_PRECHG: assert property (|pair_result_ready |-> $past(precharge_active))
        else $error("no precharge");
    AST_CTL_OUT: assert property (wb_ack_o && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i == 4'hf
        |-> reference_3v == wb_dat_i[CTL_REFLVL]
        && reference_dac_code == wb_dat_i[DAC_BITS-1:0])
        else $error("reference outputs wrong");
endmodule

bind scc_top scc_top_sva scc_top_sva_inst (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .pair_conversion_start, .busy_int,
    .pair_sample_hold, .pair_result_ready, .pair_power_down, .precharge_active,
    .reference_3v, .reference_dac_code);

// >>> test/scc_host_model.sv
// host controller model: conversion start levels and external clock
// assumes busy is given as the level of the held-pairs vector
`timescale 1ns/1ps

module scc_host_model
    import scc_pkg::*;
#(
    parameter int HALF = 4
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // conversion status and clock enable
    input wire logic busy,
    input wire logic ext_en,
    // pins
    output logic [PAIRS-1:0] pair_conversion_start,
    output logic external_conversion_clock
);
    int ph = 0;
    initial pair_conversion_start = '0;
    initial external_conversion_clock = 1'b0;
    // clock runs only during conversions, parked low between them; even halves
    always @(posedge sys_clk) begin
        if (rst || !ext_en || !busy) begin
            external_conversion_clock <= 1'b0;
            ph <= 0;
        end else if (ph == HALF - 1) begin
            external_conversion_clock <= !external_conversion_clock;
            ph <= 0;
        end else begin
            ph <= ph + 1;
        end
    end
    // levels are held by the caller for the whole conversion
    task automatic drive(input logic [PAIRS-1:0] lv);
        @(posedge sys_clk);
        pair_conversion_start <= lv;
    endtask
endmodule

// >>> test/scc_top_test.sv
// self-checking bench for the conversion control top level
// assumes the host model drives the start pins and the external clock
`timescale 1ns/1ps

module scc_top_test;
    import scc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'd48;
    logic wb_ack_o, external_conversion_clock, busy_int, precharge_active, reference_3v;
    logic range_pin = 1'b0, ext_en = 1'b0;
    logic [PAIRS-1:0] pair_conversion_start, hold, ready, pdown, wide;
    logic [DAC_BITS-1:0] dac;
    logic [31:0] rd_q[$];
    logic [PAIRS-1:0] rdy_q[$];
    int err_count = 0, compares = 0, n;
    always #5 sys_clk = !sys_clk;
    scc_host_model #(.HALF(4)) scc_host_model_inst (.sys_clk, .rst, .busy(|hold), .ext_en,
        .pair_conversion_start, .external_conversion_clock);
    scc_top scc_top_inst (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pair_conversion_start,
        .external_conversion_clock, .range_pin, .busy_int, .pair_sample_hold(hold),
        .pair_result_ready(ready), .pair_power_down(pdown), .pair_range_wide(wide),
        .precharge_active, .reference_3v, .reference_dac_code(dac));
    // --------------------
    // helpers
    // --------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic go(input logic [PAIRS-1:0] lv);
        scc_host_model_inst.drive(lv);
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= we ? 4'hf : seed[3:0];
        wb_dat_i <= dat;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, adr, ~seed);
    endtask
    // cycles from the call to the ready pulse
    task automatic wait_ready(input logic [PAIRS-1:0] exp, output int c);
        rdy_q.push_back(exp);
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (ready === 3'b000);
        repeat (2) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
            check(wb_dat_o, rd_q.pop_front());
        end
        if (ready !== 3'b000) begin
            if (rdy_q.size() == 0) err_count++;
            else check(32'(ready), 32'(rdy_q.pop_front()));
        end
    end
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
    // --------------------
    // tests
    // --------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        check(32'(busy_int), 32'h0);
        check(32'(dac), 32'h3ff);
        rd(ADDR_CTRL, CTL_RESET);
        rd(4'hf, 32'h0);
        rd(ADDR_STEP, 32'(REF_STEP_2V5_UV));
        $display("test 1 done");
        // single pair, late start on another pair is blocked
        range_pin <= 1'b1;
        go(3'b010);
        repeat (20) @(posedge sys_clk);
        go(3'b110);
        wait_ready(3'b010, n);
        check(32'(n + 21 >= 110 && n + 21 <= 120), 32'h1);
        check(32'(wide), 32'h7);
        range_pin <= 1'b0;
        go(3'b000);
        repeat (4) @(posedge sys_clk);
        check(32'(wide), 32'h7);
        check(32'(pdown), 32'h0);
        $display("test 2 done");
        // early release of one pair
        go(3'b011);
        repeat (30) @(posedge sys_clk);
        go(3'b001);
        wait_ready(3'b001, n);
        check(32'(pdown), 32'h2);
        go(3'b000);
        $display("test 3 done");
        // software mode, 3 V reference, random dac code, range bits
        seed = xs(seed);
        wb(1'b1, ADDR_CTRL, {seed[31:18], 3'b101, 5'b01010, seed[9:0]});
        check(32'(dac), 32'(seed[9:0]));
        check(32'(reference_3v), 32'h1);
        check(32'(wide), 32'h5);
        rd(ADDR_STEP, 32'(REF_STEP_3V_UV));
        go(3'b110);
        repeat (8) @(posedge sys_clk);
        check(32'(busy_int), 32'h0);
        go(3'b111);
        wait_ready(3'b111, n);
        go(3'b000);
        $display("test 4 done");
        // external conversion clock
        ext_en <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h0000_2400 | 32'(seed[9:0]));
        go(3'b001);
        wait_ready(3'b111, n);
        check(32'(n >= 148 && n <= 162), 32'h1);
        go(3'b000);
        $display("test 5 done");
        // inverted busy polarity
        ext_en <= 1'b0;
        seed = xs(seed);
        wb(1'b1, ADDR_CTRL, 32'h0000_1000 | 32'(seed[9:0]));
        repeat (3) @(posedge sys_clk);
        check(32'(busy_int), 32'h1);
        go(3'b100);
        repeat (4) @(posedge sys_clk);
        check(32'(busy_int), 32'h0);
        wait_ready(3'b100, n);
        check(32'(busy_int), 32'h1);
        go(3'b000);
        $display("test 6 done");
        check(32'(rd_q.size() + rdy_q.size()), 32'h0);
        stop_test();
    end
endmodule
